// ===== hdl/dsi_gate_or.sv
// Masks each pending source by its gate and ORs the survivors.
// Assumes pending and gates share one clock domain.
module dsi_gate_or #(
    parameter int N = 12
) (
    input wire logic [N-1:0] pending,
    input wire logic [N-1:0] gates,
    output logic any
);

    // ------------------------------------------------------------------------
    // Gate then reduce
    // ------------------------------------------------------------------------
    assign any = |(pending & gates);

endmodule // dsi_gate_or

// ===== hdl/dsi_pkg.sv
// Types of the device status and interrupt gate block.
// Assumes dsi_regs.svh provides the numeric constants.
package dsi_pkg;

    // ------------------------------------------------------------------------
    // Start-up sequence states, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [5:0] {
        DSI_ST_BIAS        = 6'b00_0001,
        DSI_ST_LOAD_COMMON = 6'b00_0010,
        DSI_ST_LOAD_USER   = 6'b00_0100,
        DSI_ST_APLL        = 6'b00_1000,
        DSI_ST_DONE        = 6'b01_0000,
        DSI_ST_HOLD        = 6'b10_0000
    } dsi_state_t;

    // Register word and source vector
    typedef logic [15:0] dsi_word_t;
    typedef logic [11:0] dsi_src_t;
    typedef logic [1:0] dsi_profile_t;

endpackage : dsi_pkg

// ===== hdl/dsi_regs.svh
// Offsets, fields, reset values and timing of the status block.
// Assumes inclusion by bare name.
`ifndef DSI_REGS_SVH
`define DSI_REGS_SVH

// ----------------------------------------------------------------------------
// Register access port
// ----------------------------------------------------------------------------
`define DSI_ADDR_W 8
`define DSI_DATA_W 16
`define DSI_OFS_STARTUP_STATUS 8'h00
`define DSI_OFS_SOURCE_GATES 8'h01
`define DSI_RDATA_ZERO 16'h0000

// ----------------------------------------------------------------------------
// Start-up status fields
// ----------------------------------------------------------------------------
`define DSI_STS_W 8
`define DSI_STS_RESET 8'h00
`define DSI_STS_TMO_LSB 5
`define DSI_STS_TMO_MSB 7
`define DSI_STS_RING_BIT 4
`define DSI_STS_READY_BIT 3
`define DSI_STS_PROF_LSB 0
`define DSI_STS_PROF_MSB 1
`define DSI_TMO_BIAS 0
`define DSI_TMO_OTP 1
`define DSI_TMO_APLL 2
`define DSI_PROF_RESET 2'h0

// ----------------------------------------------------------------------------
// Interrupt source gate fields
// ----------------------------------------------------------------------------
`define DSI_GATES_RESET 16'h0000
`define DSI_GATES_WR_MASK 16'h8fff
`define DSI_GATE_GLOBAL_BIT 15
`define DSI_SRC_N 12
`define DSI_GATE_SRC_MSB 11

// ----------------------------------------------------------------------------
// Start-up timing
// ----------------------------------------------------------------------------
`define DSI_CLK_HZ 10000000
`define DSI_HZ_PER_MHZ 1000000
`define DSI_BIAS_TMO_US 2000
`define DSI_OTP_TMO_US 10000
`define DSI_APLL_TMO_US 2000
`define DSI_TMO_CNT_W 17

`endif

// ===== hdl/dsi_timeout.sv
// Start-up phase watchdog: flags expiry of its phase.
// Assumes run is a sequencer level; clk_en freezes counting.
`include "dsi_regs.svh"

module dsi_timeout #(
    parameter int LIMIT = 20000,
    parameter int CNT_W = `DSI_TMO_CNT_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic run,
    output logic expired
);

    logic [CNT_W-1:0] count_r;
    logic expired_r;

    // ------------------------------------------------------------------------
    // Cycle counter, cleared while the phase is idle
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            count_r <= '0;
            expired_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run)
            begin
                count_r <= '0;
                expired_r <= 1'b0;
            end
            else if (count_r == CNT_W'(LIMIT - 1))
                expired_r <= 1'b1; // Limit reached, hold count
            else
                count_r <= count_r + CNT_W'(1);
        end
    end

    assign expired = expired_r;

endmodule // dsi_timeout

// ===== hdl/dsi_top.sv
// Device status and interrupt source gate logic of the clock synthesizer.
// Assumes a serial port engine drives the register port on sys_clk.
//
// Function
// - Flag bias calibration not done within 2 ms of start-up.
// - Flag configuration load not done within 10 ms of the load start.
// - Flag analog loop not locked within 2 ms during start-up.
// - Flag ring oscillator substitution for a silent clock divider during start-up.
// - Flag load done once the configuration load completes at start-up.
// - Report which user profile was loaded in bits 1:0.
// - Always load the common configuration, whatever the user profile.
// - Interrupt out only while global gate bit 15 and global pending are set.
// - Gate bit 11 passes loader failure pending to the interrupt.
// - Gate bit 10 passes loader CRC error pending to the interrupt.
// - Gate bit 9 passes manual fuse read ready pending to the interrupt.
// - Gate bit 8 passes complement input activity pending.
// - Gate bit 7 passes true input activity pending.
// - Gate bit 6 passes crystal signal loss pending.
// - Gate bit 5 passes complement input signal loss pending.
// - Gate bit 4 passes true input signal loss pending.
// - Gate bit 3 passes digital loop state change pending.
// - Gate bit 2 passes digital loop holdover pending.
// - Gate bit 1 passes digital loop loss of lock pending.
// - Gate bit 0 passes analog loop loss of lock pending.
// - Global pending ORs gated sources; status pin carries the interrupt if selected.
`include "dsi_regs.svh"

module dsi_top #(
    parameter int BIAS_TMO_CYC = `DSI_BIAS_TMO_US * (`DSI_CLK_HZ / `DSI_HZ_PER_MHZ),
    parameter int OTP_TMO_CYC = `DSI_OTP_TMO_US * (`DSI_CLK_HZ / `DSI_HZ_PER_MHZ),
    parameter int APLL_TMO_CYC = `DSI_APLL_TMO_US * (`DSI_CLK_HZ / `DSI_HZ_PER_MHZ)
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Register access port
    input wire logic [`DSI_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire dsi_pkg::dsi_word_t reg_wdata,
    output dsi_pkg::dsi_word_t reg_rdata,
    // Start-up handshakes
    output logic bias_cal_start,
    input wire logic bias_cal_done,
    output logic otp_load_req,
    output logic otp_load_common,
    input wire logic otp_load_done,
    input wire dsi_pkg::dsi_profile_t otp_user_profile,
    input wire logic apll_locked,
    input wire logic ring_osc_switched,
    output logic startup_done,
    // Pending event sources
    input wire dsi_pkg::dsi_src_t src_pending,
    // Interrupt and status pin
    input wire logic status_pin_sel,
    output logic device_irq,
    output logic status_pin
);

    import dsi_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    dsi_state_t state_r;
    dsi_state_t state_nxt;
    logic [2:0] tmo_flags_r;
    logic ring_fallback_r;
    logic load_done_r;
    dsi_profile_t profile_r;
    dsi_word_t gates_r;
    dsi_word_t rdata_r;
    logic bias_start_r;
    logic load_req_r;
    logic load_common_r;
    logic done_r;
    logic irq_r;
    logic pin_r;
    logic bias_run;
    logic otp_run;
    logic apll_run;
    logic bias_expired;
    logic otp_expired;
    logic apll_expired;
    logic gated_any;
    logic irq_nxt;
    logic in_startup;
    logic [`DSI_STS_W-1:0] status_word;
    dsi_src_t src_gates;

    // ------------------------------------------------------------------------
    // Phase watchdogs
    // ------------------------------------------------------------------------
    assign bias_run = (state_r == DSI_ST_BIAS);
    assign otp_run = (state_r == DSI_ST_LOAD_COMMON) || (state_r == DSI_ST_LOAD_USER);
    assign apll_run = (state_r == DSI_ST_APLL);
    assign in_startup = (state_r != DSI_ST_DONE);

    // Bias calibration limit
    dsi_timeout #(
        .LIMIT(BIAS_TMO_CYC),
        .CNT_W(`DSI_TMO_CNT_W)
    ) u_bias_tmo (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .run(bias_run),
        .expired(bias_expired)
    );

    // Configuration load limit, covering common and user loads
    dsi_timeout #(
        .LIMIT(OTP_TMO_CYC),
        .CNT_W(`DSI_TMO_CNT_W)
    ) u_otp_tmo (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .run(otp_run),
        .expired(otp_expired)
    );

    // Analog loop lock limit
    dsi_timeout #(
        .LIMIT(APLL_TMO_CYC),
        .CNT_W(`DSI_TMO_CNT_W)
    ) u_apll_tmo (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .run(apll_run),
        .expired(apll_expired)
    );

    // ------------------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------------------
    // Next state; a timeout lets the sequence move on so status stays readable
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            DSI_ST_BIAS:
            begin
                if (bias_cal_done || bias_expired)
                    state_nxt = DSI_ST_LOAD_COMMON;
            end
            DSI_ST_LOAD_COMMON:
            begin
                if (otp_expired)
                    state_nxt = DSI_ST_APLL;
                else if (otp_load_done && !load_req_r)
                    state_nxt = DSI_ST_LOAD_USER;
            end
            DSI_ST_LOAD_USER:
            begin
                if (otp_expired)
                    state_nxt = DSI_ST_APLL;
                else if (otp_load_done && !load_req_r)
                    state_nxt = DSI_ST_APLL;
            end
            DSI_ST_APLL:
            begin
                if (apll_locked || apll_expired)
                    state_nxt = DSI_ST_HOLD;
            end
            DSI_ST_HOLD:
                state_nxt = DSI_ST_DONE;
            DSI_ST_DONE:
                state_nxt = DSI_ST_DONE;
            default:
                state_nxt = DSI_ST_BIAS;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            state_r <= DSI_ST_BIAS;
        else if (clk_en)
            state_r <= state_nxt;
    end

    // Bias calibration start, high through the bias phase
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            bias_start_r <= 1'b0;
        else if (clk_en)
            bias_start_r <= (state_nxt == DSI_ST_BIAS);
    end

    // Load request pulse on entry to each load phase, common first
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            load_req_r <= 1'b0;
            load_common_r <= 1'b0;
        end
        else if (clk_en)
        begin
            load_req_r <= (state_nxt != state_r) &&
                          ((state_nxt == DSI_ST_LOAD_COMMON) ||
                           (state_nxt == DSI_ST_LOAD_USER));
            if (state_nxt == DSI_ST_LOAD_COMMON)
                load_common_r <= 1'b1;
            else if (state_nxt == DSI_ST_LOAD_USER)
                load_common_r <= 1'b0;
        end
    end

    // Sequence finished marker
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            done_r <= 1'b0;
        else if (clk_en)
            done_r <= (state_nxt == DSI_ST_DONE);
    end

    // ------------------------------------------------------------------------
    // Start-up status capture
    // ------------------------------------------------------------------------
    // Timeout flags set only inside their own phase, then held
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tmo_flags_r <= 3'b000;
        else if (clk_en)
        begin
            if (bias_run && bias_expired && !bias_cal_done)
                tmo_flags_r[`DSI_TMO_BIAS] <= 1'b1;
            if (otp_run && otp_expired)
                tmo_flags_r[`DSI_TMO_OTP] <= 1'b1;
            if (apll_run && apll_expired && !apll_locked)
                tmo_flags_r[`DSI_TMO_APLL] <= 1'b1;
        end
    end

    // Ring oscillator substitution seen during start-up
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            ring_fallback_r <= 1'b0;
        else if (clk_en && in_startup && ring_osc_switched)
            ring_fallback_r <= 1'b1;
    end

    // Load done and profile index at completion of the user load
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            load_done_r <= 1'b0;
            profile_r <= `DSI_PROF_RESET;
        end
        else if (clk_en && (state_r == DSI_ST_LOAD_USER) && otp_load_done &&
                 !load_req_r && !otp_expired)
        begin
            load_done_r <= 1'b1;
            profile_r <= otp_user_profile;
        end
    end

    // Status word; no register write reaches these fields
    always_comb
    begin
        status_word = `DSI_STS_RESET;
        status_word[`DSI_STS_TMO_MSB:`DSI_STS_TMO_LSB] = tmo_flags_r;
        status_word[`DSI_STS_RING_BIT] = ring_fallback_r;
        status_word[`DSI_STS_READY_BIT] = load_done_r;
        status_word[`DSI_STS_PROF_MSB:`DSI_STS_PROF_LSB] = profile_r;
    end

    // ------------------------------------------------------------------------
    // Interrupt source gates
    // ------------------------------------------------------------------------
    // Host write, reserved bits masked off
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            gates_r <= `DSI_GATES_RESET;
        else if (clk_en && reg_wr && (reg_addr == `DSI_OFS_SOURCE_GATES))
            gates_r <= reg_wdata & `DSI_GATES_WR_MASK;
    end

    // Per-source gates, bit n gates source n
    assign src_gates = gates_r[`DSI_GATE_SRC_MSB:0];

    // Gate and OR all twelve pending sources
    dsi_gate_or #(
        .N(`DSI_SRC_N)
    ) u_gate_or (
        .pending(src_pending),
        .gates(src_gates),
        .any(gated_any)
    );

    // Global gate on the combined pending status
    assign irq_nxt = gates_r[`DSI_GATE_GLOBAL_BIT] && gated_any;

    // Interrupt and status pin registers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            irq_r <= 1'b0;
            pin_r <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_r <= irq_nxt;
            pin_r <= status_pin_sel ? irq_nxt : apll_locked;
        end
    end

    // ------------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------------
    // Read data registered at the read strobe
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rdata_r <= `DSI_RDATA_ZERO;
        else if (clk_en && reg_rd)
        begin
            if (reg_addr == `DSI_OFS_STARTUP_STATUS)
                rdata_r <= {{(`DSI_DATA_W - `DSI_STS_W){1'b0}}, status_word};
            else if (reg_addr == `DSI_OFS_SOURCE_GATES)
                rdata_r <= gates_r;
            else
                rdata_r <= `DSI_RDATA_ZERO; // Unmapped offset
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign bias_cal_start = bias_start_r;
    assign otp_load_req = load_req_r;
    assign otp_load_common = load_common_r;
    assign startup_done = done_r;
    assign device_irq = irq_r;
    assign status_pin = pin_r;

endmodule // dsi_top

// ===== testbench/dsi_startup_model.sv
// Behavioural bias calibrator, configuration memory and analog loop.
// Assumes ans_dly changes only in reset; zero means never answer.
module dsi_startup_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic bias_cal_start,
    input wire logic otp_load_req,
    input wire logic otp_load_common,
    input wire logic [7:0] ans_dly,
    output logic bias_cal_done,
    output logic otp_load_done,
    output logic apll_locked,
    output logic user_after_common
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] bias_cnt_r, load_cnt_r, lock_cnt_r;
    logic load_busy_r, common_seen_r;

    // Calibration answers ans_dly cycles into bias
    always_ff @(posedge sys_clk)
    begin
        if (reset || !bias_cal_start)
        begin
            bias_cnt_r <= 8'h00;
            bias_cal_done <= 1'b0;
        end
        else
        begin
            bias_cnt_r <= bias_cnt_r + 8'h01;
            bias_cal_done <= (ans_dly != 8'h00) && (bias_cnt_r >= ans_dly);
        end
    end

    // Each load request clears done, answers ans_dly later
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            load_busy_r <= 1'b0;
            load_cnt_r <= 8'h00;
            otp_load_done <= 1'b0;
        end
        else if (otp_load_req)
        begin
            load_busy_r <= 1'b1;
            load_cnt_r <= 8'h00;
            otp_load_done <= 1'b0;
        end
        else if (load_busy_r)
        begin
            load_cnt_r <= load_cnt_r + 8'h01;
            if (ans_dly != 8'h00 && load_cnt_r >= ans_dly)
            begin
                otp_load_done <= 1'b1;
                load_busy_r <= 1'b0;
            end
        end
    end

    // Lock ans_dly cycles after reset; load order
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            lock_cnt_r <= 8'h00;
            apll_locked <= 1'b0;
            common_seen_r <= 1'b0;
            user_after_common <= 1'b0;
        end
        else
        begin
            if (lock_cnt_r != 8'hff)
                lock_cnt_r <= lock_cnt_r + 8'h01;
            apll_locked <= (ans_dly != 8'h00) && (lock_cnt_r >= ans_dly);
            if (otp_load_req && otp_load_common)
                common_seen_r <= 1'b1;
            if (otp_load_req && !otp_load_common && common_seen_r)
                user_after_common <= 1'b1;
        end
    end
endmodule // dsi_startup_model

// ===== testbench/dsi_top_asserts.sv
// Port checks of the status and interrupt gate block.
// Assumes one clock and a synchronous active-high reset.
`include "dsi_regs.svh"

module dsi_top_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [`DSI_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire dsi_pkg::dsi_word_t reg_wdata,
    input wire dsi_pkg::dsi_word_t reg_rdata,
    input wire logic otp_load_req,
    input wire logic otp_load_common,
    input wire dsi_pkg::dsi_src_t src_pending,
    input wire logic status_pin_sel,
    input wire logic device_irq,
    input wire logic status_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import dsi_pkg::*;

    // ------------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------------
    dsi_word_t gsh_r;
    logic common_seen_r;
    logic irq_want;

    // Gate register shadow
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            gsh_r <= 16'h0000;
        else if (clk_en && reg_wr && reg_addr == `DSI_OFS_SOURCE_GATES)
            gsh_r <= reg_wdata & `DSI_GATES_WR_MASK;
    end

    // Common load seen since reset
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            common_seen_r <= 1'b0;
        else if (otp_load_req && otp_load_common)
            common_seen_r <= 1'b1;
    end

    assign irq_want = gsh_r[15] && (|(src_pending & gsh_r[11:0]));

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    sequence s_irq_cause;
        clk_en && irq_want;
    endsequence
    sequence s_user_req;
        otp_load_req && !otp_load_common;
    endsequence

    property p_irq_set;
        s_irq_cause |=> device_irq;
    endproperty
    property p_irq_mask;
        clk_en && !irq_want |=> !device_irq;
    endproperty
    property p_irq_rise;
        $rose(device_irq) |-> $past(irq_want);
    endproperty
    property p_pin_irq;
        clk_en && status_pin_sel |=> status_pin == device_irq;
    endproperty
    property p_freeze;
        !clk_en |=> $stable(device_irq) && $stable(reg_rdata);
    endproperty
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    property p_rd_unmapped;
        clk_en && reg_rd && reg_addr > `DSI_OFS_SOURCE_GATES |=> reg_rdata == 16'h0000;
    endproperty
    property p_rd_gates;
        clk_en && reg_rd && reg_addr == `DSI_OFS_SOURCE_GATES |=> reg_rdata == $past(gsh_r);
    endproperty
    property p_common_first;
        s_user_req |-> common_seen_r;
    endproperty

    a_irq_set: assert property (p_irq_set)
        else $error("irq missing");
    a_irq_mask: assert property (p_irq_mask)
        else $error("irq while masked");
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rose uncaused");
    a_pin_irq: assert property (p_pin_irq)
        else $error("status pin not irq");
    a_freeze: assert property (p_freeze)
        else $error("moved while frozen");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("rdata moved unread");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read nonzero");
    a_rd_gates: assert property (p_rd_gates)
        else $error("gates readback wrong");
    a_common_first: assert property (p_common_first)
        else $error("user load before common");
endmodule // dsi_top_asserts

bind dsi_top dsi_top_asserts dsi_top_asserts_i (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .otp_load_req(otp_load_req), .otp_load_common(otp_load_common),
    .src_pending(src_pending), .status_pin_sel(status_pin_sel),
    .device_irq(device_irq), .status_pin(status_pin)
);

// ===== testbench/testbench.sv
// Self-checking bench of the status and gate block.
// Assumes short start-up timeouts of 8, 16 and 8 cycles.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dsi_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1, clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    dsi_word_t reg_wdata = 16'h0000;
    dsi_word_t reg_rdata;
    logic bias_cal_start, bias_cal_done, otp_load_req, otp_load_common, otp_load_done;
    dsi_profile_t otp_user_profile = 2'h0;
    logic apll_locked, startup_done, device_irq, status_pin, user_after_common;
    logic ring_osc_switched = 1'b0, status_pin_sel = 1'b0;
    dsi_src_t src_pending = 12'h000;
    logic [7:0] ans_dly = 8'h03;
    int miscompares = 0, num_checks = 0;

    dsi_top #(.BIAS_TMO_CYC(8), .OTP_TMO_CYC(16), .APLL_TMO_CYC(8)) dsi_top_i (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .bias_cal_start(bias_cal_start), .bias_cal_done(bias_cal_done),
        .otp_load_req(otp_load_req), .otp_load_common(otp_load_common),
        .otp_load_done(otp_load_done), .otp_user_profile(otp_user_profile),
        .apll_locked(apll_locked), .ring_osc_switched(ring_osc_switched),
        .startup_done(startup_done), .src_pending(src_pending),
        .status_pin_sel(status_pin_sel), .device_irq(device_irq), .status_pin(status_pin));

    dsi_startup_model dsi_startup_model_i (
        .sys_clk(sys_clk), .reset(reset), .bias_cal_start(bias_cal_start),
        .otp_load_req(otp_load_req), .otp_load_common(otp_load_common), .ans_dly(ans_dly),
        .bias_cal_done(bias_cal_done), .otp_load_done(otp_load_done),
        .apll_locked(apll_locked), .user_after_common(user_after_common));

    // 10 MHz clock
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic complete_run();
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input dsi_word_t seen, input dsi_word_t exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input dsi_word_t data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr, output dsi_word_t data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        data = reg_rdata;
    endtask

    task automatic do_reset(input logic [7:0] dly);
        @(negedge sys_clk);
        ans_dly = dly;
        reset = 1'b1;
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
    endtask

    task automatic wait_done();
        int n;
        for (n = 0; n < 400 && startup_done !== 1'b1; n++)
            @(negedge sys_clk);
        if (startup_done !== 1'b1)
        begin
            miscompares++;
            complete_run();
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_normal_start();
        dsi_word_t v;
        rd(8'h00, v);
        check("status_reset", v, 16'h0000);
        rd(8'h01, v);
        check("gates_reset", v, 16'h0000);
        otp_user_profile = 2'h2;
        ring_osc_switched = 1'b1;
        @(negedge sys_clk);
        ring_osc_switched = 1'b0;
        wait_done();
        rd(8'h00, v);
        check("status_done", v, 16'h001a);
        check("load_order", 16'(user_after_common), 16'h0001);
        check("pin_lock", 16'(status_pin), 16'h0001);
        otp_user_profile = 2'h1;
        wr(8'h00, 16'hffff);
        rd(8'h00, v);
        check("status_kept", v, 16'h001a);
        wr(8'h01, 16'hffff);
        rd(8'h01, v);
        check("gates_masked", v, 16'h8fff);
        rd(8'h7f, v);
        check("unmapped", v, 16'h0000);
    endtask

    task automatic t_irq_gates();
        logic [11:0] seen_on;
        logic [11:0] seen_off;
        dsi_word_t bit_w;
        for (int n = 0; n < 12; n++)
        begin
            bit_w = 16'h0001 << n;
            wr(8'h01, 16'h8000 | bit_w);
            src_pending = bit_w[11:0];
            @(negedge sys_clk);
            seen_on[n] = device_irq;
            src_pending = ~bit_w[11:0];
            @(negedge sys_clk);
            seen_off[n] = device_irq;
        end
        check("gates_low", {4'h0, seen_off[5:0], seen_on[5:0]}, 16'h003f);
        check("gates_high", {4'h0, seen_off[11:6], seen_on[11:6]}, 16'h003f);
        status_pin_sel = 1'b1;
        wr(8'h01, 16'h0fff);
        src_pending = 12'hfff;
        @(negedge sys_clk);
        check("global_off", 16'(device_irq), 16'h0000);
        wr(8'h01, 16'h8fff);
        @(negedge sys_clk);
        check("global_on", 16'({status_pin, device_irq}), 16'h0003);
        clk_en = 1'b0;
        src_pending = 12'h000;
        repeat (2) @(negedge sys_clk);
        check("frozen", 16'(device_irq), 16'h0001);
        clk_en = 1'b1;
        @(negedge sys_clk);
        check("released", 16'({status_pin, device_irq}), 16'h0000);
    endtask

    task automatic t_timeouts();
        dsi_word_t v;
        do_reset(8'h00);
        wait_done();
        rd(8'h00, v);
        check("status_tmo", v, 16'h00e0);
    endtask

    // Main sequence
    initial
    begin
        do_reset(8'h03);
        t_normal_start();
        t_irq_gates();
        t_timeouts();
        complete_run();
    end
endmodule // testbench
